// *** bench/scbl_exec_asserts.sv ***
// Purpose: port checker for the execution unit
// Assumes: three clocks per processor cycle
// Notes: done is seen one edge after the commit edge
`timescale 1ns/1ps
module scbl_exec_asserts
  import scbl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // instruction and pins
  input wire logic start_i,
  input wire logic [7:0] byte0_i,
  input wire logic [7:0] byte1_i,
  input wire logic interrupt_i,
  // outputs
  input wire logic mem_rd_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic run_wait_o,
  input wire logic [7:0] psl_o,
  input wire logic [7:0] psu_o,
  input wire logic [55:0] regs_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // an instruction taken in idle whose masked opcode matches
  sequence take_s(logic [7:0] m, logic [7:0] op);
    start_i && !busy_o && run_wait_o && ((byte0_i & m) == op);
  endsequence

  ////////////////////////////////////////
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  imm_timing_a: assert property (take_s(8'hbc, OPC_XOR_IMM) |=>
    !done_o [*6] ##1 done_o) else $error("immediate op timing");
  abs_timing_a: assert property (take_s(8'hbc, OPC_XOR_ABS) ##0
    !byte1_i[7] |-> ##13 done_o) else $error("absolute op timing");
  halt_wait_a: assert property (take_s(8'hff, OPC_HALT) |->
    ##7 (done_o && !run_wait_o)) else $error("halt not in wait");
  wait_hold_a: assert property (!run_wait_o && !interrupt_i &&
    !$past(interrupt_i) && !$past(interrupt_i, 2) |=> !run_wait_o)
    else $error("left wait without cause");
  wake_bound_a: assert property ($rose(interrupt_i) && !run_wait_o
    |-> ##[1:6] run_wait_o) else $error("no wake on interrupt");
  halt_quiet_a: assert property (!run_wait_o |=>
    $stable(psl_o) && $stable(regs_o)) else $error("state moved in wait");
  clr_lower_a: assert property (take_s(8'hff, OPC_CLR_LOWER) |=>
    ##9 ((psl_o & $past(byte1_i, 10)) == 8'h00 &&
    ((psl_o ^ $past(psl_o, 10)) & ~$past(byte1_i, 10)) == 8'h00))
    else $error("lower clear wrong");
  clr_upper_a: assert property (take_s(8'hff, OPC_CLR_UPPER) |=>
    ##9 ((psu_o & $past(byte1_i, 10) & PSU_WRITABLE) == 8'h00 &&
    ((psu_o ^ $past(psu_o, 10)) & ~$past(byte1_i, 10) & 8'h67) == 8'h00))
    else $error("upper clear wrong");
  dar_flags_a: assert property (take_s(8'hfc, OPC_DAR) |=>
    ##9 ((psl_o ^ $past(psl_o, 10)) & 8'h21) == 8'h00)
    else $error("adjust moved carry flags");
  logic_flags_a: assert property (take_s(8'hbc, OPC_XOR_IMM) |=>
    ##6 ((psl_o ^ $past(psl_o, 7)) & 8'h3f) == 8'h00)
    else $error("logic op moved flags");
  regz_cc_a: assert property (take_s(8'hbc, OPC_XOR_REGZ) |->
    ##7 psl_o[7:6] == (regs_o[7:0] == 8'h00 ? 2'h0 :
    (regs_o[7] ? 2'h2 : 2'h1))) else $error("cc wrong for r0");
  read_busy_a: assert property (mem_rd_o |-> busy_o)
    else $error("read outside an op");
endmodule

bind scbl_exec scbl_exec_asserts scbl_exec_asserts_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
  .byte0_i(byte0_i), .byte1_i(byte1_i), .interrupt_i(interrupt_i),
  .mem_rd_o(mem_rd_o), .busy_o(busy_o), .done_o(done_o),
  .run_wait_o(run_wait_o), .psl_o(psl_o), .psu_o(psu_o),
  .regs_o(regs_o));

// *** bench/scbl_exec_tb.sv ***
// Purpose: self-checking bench for the execution unit
// Assumes: memory partner answers low address byte xor 3c
// Notes: rows run in order, each builds on the registers before it
`timescale 1ns/1ps
module scbl_exec_tb;
  import scbl_pkg::*;

  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [12:0] na;
    logic [7:0] clks;
    logic [31:0] rg;
    logic [7:0] psl;
    logic ccx;
  } scbl_row_t;

  // opcode, byte1, byte2, base, clocks, r3..r0, lower status, cc free
  localparam scbl_row_t ROWS [14] = '{
    '{8'h65, 8'h81, 8'h00, 13'h0000, 8'h06, 32'h00008100, 8'h80, 1'b0},
    '{8'h25, 8'h81, 8'h00, 13'h0000, 8'h06, 32'h00000000, 8'h00, 1'b0},
    '{8'h66, 8'h35, 8'h00, 13'h0000, 8'h06, 32'h00350000, 8'h40, 1'b0},
    '{8'h2e, 8'h01, 8'h23, 13'h0000, 8'h0c, 32'h002a0000, 8'h40, 1'b0},
    '{8'h6d, 8'h1f, 8'hff, 13'h0000, 8'h0c, 32'h002ac300, 8'h80, 1'b0},
    '{8'h2b, 8'h05, 8'h00, 13'h0100, 8'h09, 32'h392ac300, 8'h40, 1'b0},
    '{8'h6b, 8'h7f, 8'h00, 13'h0200, 8'h09, 32'hfb2ac300, 8'h80, 1'b0},
    '{8'h22, 8'h00, 8'h00, 13'h0000, 8'h06, 32'hfb2ac32a, 8'h40, 1'b0},
    '{8'h63, 8'h00, 8'h00, 13'h0000, 8'h06, 32'hfb2ac3fb, 8'h80, 1'b0},
    '{8'h2d, 8'h60, 8'h10, 13'h0000, 8'h0c, 32'hfb2ac314, 8'h40, 1'b0},
    '{8'h2a, 8'h82, 8'h00, 13'h0300, 8'h0f, 32'hfb29c314, 8'h40, 1'b0},
    '{8'h75, 8'h40, 8'h00, 13'h0000, 8'h09, 32'hfb29c314, 8'h00, 1'b0},
    '{8'h95, 8'h00, 8'h00, 13'h0000, 8'h09, 32'hfb296d14, 8'h00, 1'b1},
    '{8'h74, 8'hff, 8'h00, 13'h0000, 8'h09, 32'hfb296d14, 8'h00, 1'b1}};

  logic clk_i;
  logic rst_n_i;
  logic start_i;
  logic [7:0] byte0_i;
  logic [7:0] byte1_i;
  logic [7:0] byte2_i;
  logic [12:0] next_addr_i;
  logic interrupt_i;
  logic sense_i;
  logic [7:0] mem_rdata_i;
  logic mem_rd_o;
  logic [12:0] mem_addr_o;
  logic busy_o;
  logic done_o;
  logic run_wait_o;
  logic [7:0] psl_o;
  logic [7:0] psu_o;
  logic [55:0] regs_o;
  int n_fail;
  int n_checks;
  int n;
  scbl_row_t row;

  scbl_exec scbl_exec_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .start_i(start_i), .byte0_i(byte0_i), .byte1_i(byte1_i),
    .byte2_i(byte2_i), .next_addr_i(next_addr_i),
    .interrupt_i(interrupt_i), .sense_i(sense_i),
    .mem_rdata_i(mem_rdata_i), .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o), .busy_o(busy_o), .done_o(done_o),
    .run_wait_o(run_wait_o), .psl_o(psl_o), .psu_o(psu_o),
    .regs_o(regs_o));

  scbl_mem_model scbl_mem_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
    .mem_rdata_o(mem_rdata_i));

  ////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                     input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %0h want %0h", $time, what,
               seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // n counts edges after the taking edge until done is seen
  task automatic run_op(input logic [7:0] b0, input logic [7:0] b1,
                        input logic [7:0] b2, input logic [12:0] na);
    @(posedge clk_i);
    start_i <= 1'b1;
    byte0_i <= b0;
    byte1_i <= b1;
    byte2_i <= b2;
    next_addr_i <= na;
    @(posedge clk_i);
    start_i <= 1'b0;
    n = 0;
    while (n < 60 && done_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 60) begin
      n_fail++;
      $display("unexpected at %0t: no done", $time);
      end_of_test();
    end
  endtask

  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_n_i = 1'b0;
    start_i = 1'b0;
    byte0_i = 8'h00;
    byte1_i = 8'h00;
    byte2_i = 8'h00;
    next_addr_i = 13'h0000;
    interrupt_i = 1'b0;
    sense_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    chk({busy_o, done_o, run_wait_o}, 3'b001, "reset flags");
    chk(regs_o, 56'h0, "reset regs");
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      row = ROWS[i];
      run_op(row.b0, row.b1, row.b2, row.na);
      chk(n, row.clks, "clocks");
      chk(regs_o[31:0], row.rg, "regs");
      chk(psl_o & {{2{!row.ccx}}, 6'h3f}, row.psl, "status");
      $display("row %0d done", i);
    end
    chk(regs_o[55:32], 24'h0, "bank one");
    chk(psu_o, 8'h80, "upper status");
    run_op(OPC_HALT, 8'h00, 8'h00, 13'h0000);
    chk(n, 6, "halt clocks");
    chk(run_wait_o, 1'b0, "wait");
    @(posedge clk_i);
    start_i <= 1'b1;
    byte0_i <= 8'h64;
    byte1_i <= 8'hff;
    repeat (12) @(posedge clk_i);
    start_i <= 1'b0;
    #1;
    chk({busy_o, run_wait_o}, 2'b00, "start in wait");
    chk(regs_o[7:0], 8'h14, "r0 kept");
    @(posedge clk_i);
    interrupt_i <= 1'b1;
    n = 0;
    while (n < 20 && run_wait_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(run_wait_o, 1'b1, "woken");
    if (n >= 20) begin
      end_of_test();
    end
    @(posedge clk_i);
    interrupt_i <= 1'b0;
    $display("halt test done");
    run_op(OPC_HALT, 8'h00, 8'h00, 13'h0000);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    #1;
    chk(run_wait_o, 1'b1, "reset wakes");
    chk(regs_o, 56'h0, "reset clears");
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    run_op(8'h65, 8'h01, 8'h00, 13'h0000);
    chk(regs_o[15:0], 16'h0100, "after reset");
    chk(psl_o, 8'h40, "cc positive");
    $display("reset test done");
    end_of_test();
  end
endmodule

// *** bench/scbl_mem_model.sv ***
// Purpose: memory partner for the execution unit read port
// Assumes: a read is held for three clocks, data taken on the third
// Notes: data is the low address byte xor 3c; idle bus toggles
`timescale 1ns/1ps
module scbl_mem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // read port
  input wire logic mem_rd_i,
  input wire logic [12:0] mem_addr_i,
  output logic [7:0] mem_rdata_o
);
  // an unselected bus never holds the last byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rdata_o <= 8'h55;
    end else if (mem_rd_i) begin
      mem_rdata_o <= mem_addr_i[7:0] ^ 8'h3c;
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

// *** src/scbl_bcd_adjust.sv ***
// Purpose: decimal adjust correction for packed bcd
// Assumes: carry and half digit flags come from the lower status byte
// Notes: each nibble wraps on its own, no carry between nibbles
`timescale 1ns/1ps
module scbl_bcd_adjust
  import scbl_pkg::*;
(
  // operand and flags
  input wire logic [7:0] val_i,
  input wire logic carry_i,
  input wire logic half_i,
  // result
  output logic [7:0] res_o
);

  logic [7:0] corr;

  always_comb begin
    case ({carry_i, half_i})
      2'b00: corr = DAR_ADD_NONE_SET;
      2'b01: corr = DAR_ADD_HALF_SET;
      2'b11: corr = DAR_ADD_BOTH_SET;
      default: corr = DAR_ADD_CARRY_SET;
    endcase
    res_o = {4'(val_i[7:4] + corr[7:4]), 4'(val_i[3:0] + corr[3:0])};
  end

endmodule

// *** src/scbl_exec.sv ***
// Purpose: executes status clear, decimal adjust, xor, or and halt
// Assumes: instruction bytes already fetched; memory answers in one cycle
// Notes: three clocks per processor cycle; memory data taken on 3rd clock
//
// How it works
// - three clocks per processor cycle; done after cycles times three
// - clear lower status bits where operand byte holds ones, 3 cycles
// - lower clear reaches cc, half digit, bank, with carry, ovf, ucomp, cy
// - clear upper status bits selected by operand: flag, inhibit, stack
// - decimal adjust adds aa, a0, 00 or 0a per carry flags, 3 cycles
// - decimal adjust keeps carry and half digit flags unchanged
// - condition code after decimal adjust is undefined
// - absolute xor with byte at 13-bit address into r, 4 cycles
// - indexed absolute forms add index register and write register zero
// - immediate xor with second byte into r, 2 cycles
// - relative xor with byte at effective address into r, 3 cycles
// - register xor of r into register zero, r kept, 2 cycles
// - logic ops set cc: positive 01, zero 00, negative 10
// - halt stops execution, drives wait, 2 cycles, no status change
// - only reset or interrupt leaves the wait state
// - absolute or with byte at 13-bit address into r, 4 cycles
// - immediate or with second byte into r, 2 cycles
// - relative or with byte at effective address into r, 3 cycles
// - register or of r into register zero, r kept, 2 cycles
`timescale 1ns/1ps
module scbl_exec
  import scbl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // instruction in
  input wire logic start_i,
  input wire logic [7:0] byte0_i,
  input wire logic [7:0] byte1_i,
  input wire logic [7:0] byte2_i,
  input wire logic [12:0] next_addr_i,
  // pins
  input wire logic interrupt_i,
  input wire logic sense_i,
  // memory read port
  input wire logic [7:0] mem_rdata_i,
  output logic mem_rd_o,
  output logic [12:0] mem_addr_o,
  // status
  output logic busy_o,
  output logic done_o,
  output logic run_wait_o,
  output logic [7:0] psl_o,
  output logic [7:0] psu_o,
  output logic [55:0] regs_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PTR_HI = 3'b001,
    ST_PTR_LO = 3'b010,
    ST_OPER = 3'b011,
    ST_WAIT = 3'b100,
    ST_HALT = 3'b101
  } scbl_state_t;

  function automatic scbl_kind_t kind_of(input logic [7:0] b);
    case ({b[7:2], 2'b00})
      OPC_XOR_REGZ, OPC_XOR_IMM, OPC_XOR_REL, OPC_XOR_ABS: return OPK_XOR;
      OPC_OR_REGZ, OPC_OR_IMM, OPC_OR_REL, OPC_OR_ABS: return OPK_OR;
      OPC_DAR: return OPK_DAR;
      default: begin
        if (b == OPC_CLR_LOWER) begin
          return OPK_CLR_LOWER;
        end
        if (b == OPC_CLR_UPPER) begin
          return OPK_CLR_UPPER;
        end
        if (b == OPC_HALT) begin
          return OPK_HALT;
        end
        return OPK_NONE;
      end
    endcase
  endfunction

  function automatic scbl_mode_t mode_of(input logic [7:0] b);
    case (b[3:2])
      2'b00: return AM_REGZ;
      2'b01: return AM_IMM;
      2'b10: return AM_REL;
      default: return AM_ABS;
    endcase
  endfunction

  // register file index: r0 shared, r1..r3 per bank
  function automatic logic [2:0] reg_idx(input logic bank,
                                          input logic [1:0] r);
    if (r == 2'b00) begin
      return 3'h0;
    end
    return bank ? 3'({1'b0, r} + 3'd3) : {1'b0, r};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic int_s1_q, int_s2_q, sense_s1_q, sense_s2_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_s1_q <= 1'b0;
      int_s2_q <= 1'b0;
      sense_s1_q <= 1'b0;
      sense_s2_q <= 1'b0;
    end else begin
      int_s1_q <= interrupt_i;
      int_s2_q <= int_s1_q;
      sense_s1_q <= sense_i;
      sense_s2_q <= sense_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode of the held instruction
  scbl_state_t state_q;
  scbl_kind_t kind_q;
  scbl_mode_t mode_q;
  logic [7:0] b0_q, b1_q, b2_q;
  logic [12:0] ea_q;
  logic [7:0] oper_q;
  logic [1:0] ph_q;
  logic [5:0] clk_cnt_q, clk_total_q;
  logic [7:0] regs_q [0:6];
  logic [7:0] psl_q, psu_q;

  logic indexed, last_clk, ph_end;
  logic [2:0] r_sel, dst_sel;
  logic [7:0] r_val, src_b, lu_res, bcd_res;
  logic [1:0] lu_cc;

  assign indexed = (mode_q == AM_ABS) && (b1_q[6:5] != 2'b00);
  assign r_sel = reg_idx(psl_q[PSL_BANK], b0_q[1:0]);
  assign dst_sel = (mode_q == AM_REGZ || indexed) ? 3'h0 : r_sel;
  assign r_val = indexed ? regs_q[0] : regs_q[r_sel];
  assign last_clk = (clk_cnt_q == clk_total_q);
  assign ph_end = (ph_q == 2'(CLK_PER_CYC - 1));

  // second operand per addressing form
  always_comb begin
    case (mode_q)
      AM_REGZ: src_b = regs_q[0];
      AM_IMM: src_b = b1_q;
      default: src_b = oper_q;
    endcase
  end

  scbl_logic_unit u_lu (
    .a_i(r_val),
    .b_i(src_b),
    .or_sel_i(kind_q == OPK_OR),
    .res_o(lu_res),
    .cc_o(lu_cc)
  );

  scbl_bcd_adjust u_bcd (
    .val_i(r_val),
    .carry_i(psl_q[PSL_CARRY]),
    .half_i(psl_q[PSL_HALF_DIGIT]),
    .res_o(bcd_res)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  logic [12:0] start_ea;
  logic [5:0] start_total;
  scbl_kind_t start_kind;
  scbl_mode_t start_mode;
  logic start_ind;

  always_comb begin
    start_kind = kind_of(byte0_i);
    start_mode = (start_kind == OPK_XOR || start_kind == OPK_OR) ?
                 mode_of(byte0_i) : AM_NONE;
    start_ind = (start_mode == AM_REL || start_mode == AM_ABS) &&
                byte1_i[7];
    if (start_mode == AM_REL) begin
      start_ea = 13'(next_addr_i + {{6{byte1_i[6]}}, byte1_i[6:0]});
    end else begin
      start_ea = {byte1_i[4:0], byte2_i};
    end
    case (start_kind)
      OPK_CLR_LOWER, OPK_CLR_UPPER: start_total = 6'(CYC_PSW_CLR);
      OPK_DAR: start_total = 6'(CYC_DAR);
      OPK_HALT: start_total = 6'(CYC_HALT);
      OPK_XOR, OPK_OR: begin
        case (start_mode)
          AM_ABS: start_total = 6'(CYC_ABS);
          AM_REL: start_total = 6'(CYC_REL);
          AM_IMM: start_total = 6'(CYC_IMM);
          default: start_total = 6'(CYC_REGZ);
        endcase
      end
      default: start_total = 6'(CYC_REGZ);
    endcase
    if (start_ind) begin
      start_total = 6'(start_total + 6'(CYC_INDIRECT));
    end
    start_total = 6'(start_total * 6'(CLK_PER_CYC));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      kind_q <= OPK_NONE;
      mode_q <= AM_NONE;
      b0_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      ea_q <= 13'h0000;
      oper_q <= 8'h00;
      ph_q <= 2'h0;
      clk_cnt_q <= 6'h00;
      clk_total_q <= 6'h00;
    end else begin
      if (state_q != ST_IDLE && state_q != ST_HALT) begin
        clk_cnt_q <= 6'(clk_cnt_q + 6'h01);
      end
      ph_q <= (state_q == ST_IDLE || ph_end) ? 2'h0 : 2'(ph_q + 2'h1);
      case (state_q)
        ST_IDLE: begin
          if (start_i) begin
            kind_q <= start_kind;
            mode_q <= start_mode;
            b0_q <= byte0_i;
            b1_q <= byte1_i;
            b2_q <= byte2_i;
            ea_q <= start_ea;
            clk_cnt_q <= 6'h01;
            clk_total_q <= start_total;
            if (start_ind) begin
              state_q <= ST_PTR_HI;
            end else if (start_mode == AM_REL || start_mode == AM_ABS) begin
              state_q <= ST_OPER;
            end else begin
              state_q <= ST_WAIT;
            end
          end
        end
        ST_PTR_HI: begin
          if (ph_end) begin
            oper_q <= mem_rdata_i;
            ea_q <= 13'(ea_q + 13'h0001);
            state_q <= ST_PTR_LO;
          end
        end
        ST_PTR_LO: begin
          if (ph_end) begin
            ea_q <= {oper_q[4:0], mem_rdata_i};
            state_q <= ST_OPER;
          end
        end
        ST_OPER: begin
          if (ph_end) begin
            oper_q <= mem_rdata_i;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (last_clk) begin
            state_q <= (kind_q == OPK_HALT) ? ST_HALT : ST_IDLE;
          end
        end
        ST_HALT: begin
          if (int_s2_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // index register offset is applied when the operand address is formed
  logic [12:0] oper_addr;
  assign oper_addr = indexed ?
                     13'(ea_q + {5'h00, regs_q[r_sel]}) : ea_q;

  ////////////////////////////////////////////////////////////////////////
  // memory port
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rd_o <= 1'b0;
      mem_addr_o <= 13'h0000;
    end else begin
      mem_rd_o <= 1'b0;
      if (state_q == ST_IDLE && start_i &&
          (start_mode == AM_REL || start_mode == AM_ABS)) begin
        mem_rd_o <= 1'b1;
        mem_addr_o <= start_ea;
      end else if ((state_q == ST_PTR_HI || state_q == ST_PTR_LO) &&
                   !ph_end) begin
        mem_rd_o <= 1'b1;
      end else if (state_q == ST_PTR_HI && ph_end) begin
        mem_rd_o <= 1'b1;
        mem_addr_o <= 13'(ea_q + 13'h0001);
      end else if (state_q == ST_PTR_LO && ph_end) begin
        mem_rd_o <= 1'b1;
        mem_addr_o <= indexed ? 13'({oper_q[4:0], mem_rdata_i} +
                                    {5'h00, regs_q[r_sel]}) :
                                {oper_q[4:0], mem_rdata_i};
      end else if (state_q == ST_OPER && !ph_end) begin
        mem_rd_o <= 1'b1;
        mem_addr_o <= oper_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file and status bytes, written on the last clock
  logic commit;
  assign commit = (state_q == ST_WAIT) && last_clk;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 7; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else if (commit) begin
      case (kind_q)
        OPK_XOR, OPK_OR: regs_q[dst_sel] <= lu_res;
        OPK_DAR: regs_q[r_sel] <= bcd_res;
        default: regs_q[0] <= regs_q[0];
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psl_q <= PSL_RESET;
      psu_q <= PSU_RESET;
    end else if (commit) begin
      case (kind_q)
        OPK_CLR_LOWER: psl_q <= psl_q & ~b1_q;
        OPK_CLR_UPPER: psu_q <= psu_q & ~(b1_q & PSU_WRITABLE);
        // carry flags untouched, cc follows result as a don't-care value
        OPK_DAR: psl_q[PSL_CC_HI:PSL_CC_LO] <= cc_of(bcd_res);
        OPK_XOR, OPK_OR: psl_q[PSL_CC_HI:PSL_CC_LO] <= lu_cc;
        default: psl_q <= psl_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      run_wait_o <= 1'b1;
    end else begin
      done_o <= commit;
      busy_o <= (state_q == ST_IDLE) ? start_i :
                (state_q != ST_HALT) && !commit;
      if (commit && kind_q == OPK_HALT) begin
        run_wait_o <= 1'b0;
      end else if (state_q == ST_HALT && int_s2_q) begin
        run_wait_o <= 1'b1;
      end
    end
  end

  assign psl_o = psl_q;
  assign psu_o = {sense_s2_q, psu_q[PSU_SENSE-1:0]};
  assign regs_o = {regs_q[6], regs_q[5], regs_q[4], regs_q[3],
                   regs_q[2], regs_q[1], regs_q[0]};

endmodule

// *** src/scbl_logic_unit.sv ***
// Purpose: exclusive-or and inclusive-or with condition code result
// Assumes: purely combinational
// Notes: or is chosen when or_sel_i is high
`timescale 1ns/1ps
module scbl_logic_unit
  import scbl_pkg::*;
(
  // operands
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic or_sel_i,
  // result
  output logic [7:0] res_o,
  output logic [1:0] cc_o
);

  always_comb begin
    res_o = or_sel_i ? (a_i | b_i) : (a_i ^ b_i);
    cc_o = cc_of(res_o);
  end

endmodule

// *** src/scbl_pkg.sv ***
// Purpose: constants and types for the status clear / bcd / logic unit
// Assumes: 8-bit processor, three clocks per processor cycle
// Notes: opcodes carry the r or index field in bits 1:0
package scbl_pkg;

  localparam int unsigned CLK_PER_CYC = 3;
  localparam logic [3:0] CYC_PSW_CLR = 4'h3;
  localparam logic [3:0] CYC_DAR = 4'h3;
  localparam logic [3:0] CYC_ABS = 4'h4;
  localparam logic [3:0] CYC_IMM = 4'h2;
  localparam logic [3:0] CYC_REL = 4'h3;
  localparam logic [3:0] CYC_REGZ = 4'h2;
  localparam logic [3:0] CYC_HALT = 4'h2;
  localparam logic [3:0] CYC_INDIRECT = 4'h2;

  // opcode bytes with bits 1:0 cleared, except OPC_CLR_LOWER which is the full byte 75
  localparam logic [7:0] OPC_CLR_UPPER = 8'h74;
  localparam logic [7:0] OPC_CLR_LOWER = 8'h75;
  localparam logic [7:0] OPC_DAR = 8'h94;
  localparam logic [7:0] OPC_XOR_REGZ = 8'h20;
  localparam logic [7:0] OPC_XOR_IMM = 8'h24;
  localparam logic [7:0] OPC_XOR_REL = 8'h28;
  localparam logic [7:0] OPC_XOR_ABS = 8'h2c;
  localparam logic [7:0] OPC_HALT = 8'h40;
  localparam logic [7:0] OPC_OR_REGZ = 8'h60;
  localparam logic [7:0] OPC_OR_IMM = 8'h64;
  localparam logic [7:0] OPC_OR_REL = 8'h68;
  localparam logic [7:0] OPC_OR_ABS = 8'h6c;

  // lower status byte fields
  localparam int unsigned PSL_CC_HI = 7;
  localparam int unsigned PSL_CC_LO = 6;
  localparam int unsigned PSL_HALF_DIGIT = 5;
  localparam int unsigned PSL_BANK = 4;
  localparam int unsigned PSL_WITH_CARRY = 3;
  localparam int unsigned PSL_OVERFLOW = 2;
  localparam int unsigned PSL_UCOMP = 1;
  localparam int unsigned PSL_CARRY = 0;
  // upper status byte fields: 7 sense, 6 flag, 5 int inhibit, 2:0 stack
  localparam int unsigned PSU_SENSE = 7;
  localparam logic [7:0] PSU_WRITABLE = 8'h67;
  localparam logic [7:0] PSL_RESET = 8'h00;
  localparam logic [7:0] PSU_RESET = 8'h00;

  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_POS = 2'h1;
  localparam logic [1:0] CC_NEG = 2'h2;

  localparam logic [7:0] DAR_ADD_NONE_SET = 8'haa;
  localparam logic [7:0] DAR_ADD_HALF_SET = 8'ha0;
  localparam logic [7:0] DAR_ADD_BOTH_SET = 8'h00;
  localparam logic [7:0] DAR_ADD_CARRY_SET = 8'h0a;

  typedef enum logic [2:0] {
    OPK_NONE = 3'b000,
    OPK_CLR_LOWER = 3'b001,
    OPK_CLR_UPPER = 3'b010,
    OPK_DAR = 3'b011,
    OPK_XOR = 3'b100,
    OPK_OR = 3'b101,
    OPK_HALT = 3'b110
  } scbl_kind_t;

  typedef enum logic [2:0] {
    AM_NONE = 3'b000,
    AM_REGZ = 3'b001,
    AM_IMM = 3'b010,
    AM_REL = 3'b011,
    AM_ABS = 3'b100
  } scbl_mode_t;

  function automatic logic [1:0] cc_of(input logic [7:0] v);
    if (v == 8'h00) begin
      return CC_ZERO;
    end
    return v[7] ? CC_NEG : CC_POS;
  endfunction

endpackage
